/* logic/idc_core.sv */
// Instruction decode and execute core with watchdog and timer control
//
// Contract
// RULE_01: 000110 decodes to XOR with file, Z only
// RULE_02: 000100 decodes to OR with file, Z only
// RULE_03: 001101 rotates file left through carry
// RULE_04: 001100 rotates file right through carry
// RULE_05: 001011 decrements, skips on zero, no flags
// RULE_06: 001111 increments, skips on zero, no flags
// RULE_07: 0110 bit test skips when bit clear
// RULE_08: 0111 bit test skips when bit set
// RULE_09: 111000 ORs literal into accumulator, Z only
// RULE_10: 111010 XORs literal into accumulator, Z only
// RULE_11: 11110x literal minus accumulator, three flags
// RULE_12: 1101xx returns, loads literal, two cycles
// RULE_13: Standby word sets expiry, clears power-down
// RULE_14: Kick or standby clears watchdog and prescaler (the code clears the prescaler only when OPT_PSA assigns it to the watchdog)
// RULE_15: Watchdog time-out clears expiry flag
// RULE_16: Jumps and true skips add one idle cycle
// RULE_17: Port read-modify-write sources the pin levels
// RULE_18: File write to timer clears its prescaler
// RULE_19: 100 calls, 101 jumps, two cycles each
// RULE_20: Kick word sets expiry and power-down flags
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module idc_core
  import idc_pkg::*;
#(
  parameter int WDT_LIMIT   = WDT_CYCLES,
  parameter int FILE_DEPTH  = 16,
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [13:0] instr_word,
  input  wire logic        instr_valid,
  output logic      [10:0] fetch_addr,
  output logic             nop_cycle,
  input  wire logic [7:0]  port_pins,
  output logic      [7:0]  port_out,
  output logic      [7:0]  port_oe_n,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             wdt_reset,
  output logic             asleep
);

  localparam int FW = $clog2(FILE_DEPTH);
  localparam int SW = $clog2(STACK_DEPTH);
  localparam int WW = $clog2(WDT_LIMIT + 1);

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [4:0]  status_reg;
  logic [4:0]  status_next;
  logic [3:0]  option_reg;
  logic [7:0]  tris_reg;
  logic [7:0]  latch_reg;
  logic [7:0]  tmr_reg;
  logic [7:0]  tmr_next;
  logic [7:0]  presc_reg;
  logic [7:0]  presc_next;
  logic [WW-1:0] wdt_reg;
  logic [WW-1:0] wdt_next;
  logic [10:0] pc_reg;
  logic [10:0] pc_next;
  logic [SW-1:0] sp_reg;
  logic        flush_reg;
  logic        asleep_reg;
  logic        wdt_rst_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  mem   [FILE_DEPTH];
  logic [10:0] stack [STACK_DEPTH];

  // ****************************************
  // Decoder
  // ****************************************
  idc_dec_if dif ();
  assign dif.word = instr_word;
  idc_decode u_dec (
    .d (dif)
  );

  wire idc_op_t op = dif.op;
  wire [6:0] fa    = dif.fa;
  wire [7:0] lit   = dif.lit;

  // ****************************************
  // Operand selection
  // ****************************************
  wire       go     = instr_valid & ~flush_reg & ~asleep_reg;
  wire [FW-1:0] fidx = fa[FW-1:0];
  wire       at_prt = (fa == FA_PORT);
  wire       at_tmr = (fa == FA_TIMER);
  // Port source is the pin level, not the latch [RULE_17]
  wire [7:0] fval   = at_prt ? port_pins : at_tmr ? tmr_reg : mem[fidx];
  wire       bit_v  = fval[dif.bsel];
  wire       cin    = status_reg[ST_C];

  // ****************************************
  // Result and flag logic
  // ****************************************
  wire [8:0] sub9 = {1'b0, lit} - {1'b0, acc_reg};
  wire       sub_c  = ~sub9[8];
  wire       sub_dc = (lit[3:0] >= acc_reg[3:0]);

  wire [7:0] res =
    (op == OP_XOR)   ? (acc_reg ^ fval)       : // [RULE_01]
    (op == OP_IOR)   ? (acc_reg | fval)       : // [RULE_02]
    (op == OP_ROTL)  ? {fval[6:0], cin}       : // [RULE_03]
    (op == OP_ROTR)  ? {cin, fval[7:1]}       : // [RULE_04]
    (op == OP_DECSZ) ? (fval - 8'h01)         : // [RULE_05]
    (op == OP_INCSZ) ? (fval + 8'h01)         : // [RULE_06]
    (op == OP_IORL)  ? (acc_reg | lit)        : // [RULE_09]
    (op == OP_XORL)  ? (acc_reg ^ lit)        : // [RULE_10]
    (op == OP_SUBL)  ? sub9[7:0]              : // [RULE_11]
    lit;                                        // [RULE_12]

  wire       res_z  = (res == 8'h00);
  wire       rot_c  = (op == OP_ROTL) ? fval[7] : fval[0];

  wire is_fop = (op == OP_XOR) | (op == OP_IOR) | (op == OP_ROTL) |
                (op == OP_ROTR) | (op == OP_DECSZ) | (op == OP_INCSZ);
  wire is_lop = (op == OP_IORL) | (op == OP_XORL) | (op == OP_SUBL) |
                (op == OP_RETL);
  wire upd_z  = go & ((op == OP_XOR) | (op == OP_IOR) | (op == OP_IORL) |
                      (op == OP_XORL) | (op == OP_SUBL));
  wire upd_c  = go & ((op == OP_ROTL) | (op == OP_ROTR));
  wire do_sub = go & (op == OP_SUBL);
  wire do_kick  = go & (op == OP_KICK);
  wire do_sleep = go & (op == OP_SLEEP);
  wire wr_f   = go & is_fop & dif.dest;
  wire wr_w   = go & ((is_fop & ~dif.dest) | is_lop);

  // ****************************************
  // Flow control
  // ****************************************
  wire dec_z  = (op == OP_DECSZ) & res_z;            // [RULE_05]
  wire inc_z  = (op == OP_INCSZ) & res_z;            // [RULE_06]
  wire btc_sk = (op == OP_BTC) & ~bit_v;             // [RULE_07]
  wire bts_sk = (op == OP_BTS) & bit_v;              // [RULE_08]
  wire skip   = go & (dec_z | inc_z | btc_sk | bts_sk);
  wire do_call = go & (op == OP_CALL);
  wire do_goto = go & (op == OP_GOTO);
  wire do_ret  = go & (op == OP_RETL);
  wire [SW-1:0] sp_dec = sp_reg - SW'(1);
  wire [SW-1:0] sp_inc = sp_reg + SW'(1);
  wire [10:0]   pc_inc = pc_reg + 11'h001;

  assign pc_next =
    (do_call | do_goto) ? dif.target             : // [RULE_19]
    do_ret              ? stack[sp_dec]          : // [RULE_12]
    skip                ? (pc_reg + 11'h002)     :
    go                  ? pc_inc                 :
    pc_reg;

  // ****************************************
  // Timer, prescaler and watchdog
  // ****************************************
  wire       psa_wdt = option_reg[OPT_PSA];
  wire [8:0] lim9    = (9'h002 << option_reg[2:0]) - 9'h001;
  wire       ps_tick = (presc_reg == lim9[7:0]);
  wire       tmr_fw  = wr_f & at_tmr;
  wire       tmr_bw  = bus_wr & (bus_addr == A_TIMER);
  wire       kick_any = do_kick | do_sleep;
  wire       wdt_inc = psa_wdt ? ps_tick : 1'b1;
  wire       wdt_to  = wdt_inc & (wdt_reg == WW'(WDT_LIMIT - 1));

  assign presc_next =
    ((kick_any & psa_wdt) |                    // [RULE_14]
     (tmr_fw & ~psa_wdt) |                     // [RULE_18]
     ps_tick) ? 8'h00 : presc_reg + 8'h01;

  assign tmr_next =
    tmr_fw                 ? res       :
    tmr_bw                 ? bus_wdata :
    (~psa_wdt & ps_tick)   ? tmr_reg + 8'h01 :
    tmr_reg;

  assign wdt_next =
    (kick_any | wdt_to) ? '0 :                 // [RULE_14]
    wdt_inc             ? wdt_reg + WW'(1) :
    wdt_reg;

  // ****************************************
  // Accumulator and status
  // ****************************************
  assign acc_next = wr_w                            ? res       :
                    (bus_wr & (bus_addr == A_ACC))  ? bus_wdata :
                    acc_reg;

  always_comb begin
    status_next = status_reg;
    if (bus_wr && bus_addr == A_STATUS) begin
      status_next = bus_wdata[4:0];
    end
    if (upd_z) begin
      status_next[ST_Z] = res_z;
    end
    if (upd_c) begin
      status_next[ST_C] = rot_c;               // [RULE_03] [RULE_04]
    end
    if (do_sub) begin
      status_next[ST_C]  = sub_c;              // [RULE_11]
      status_next[ST_NIB] = sub_dc;
    end
    if (do_kick) begin
      status_next[ST_TO] = 1'b1;               // [RULE_20]
      status_next[ST_PWD] = 1'b1;
    end
    if (do_sleep) begin
      status_next[ST_TO] = 1'b1;               // [RULE_13]
      status_next[ST_PWD] = 1'b0;
    end
    if (wdt_to) begin
      status_next[ST_TO] = 1'b0;               // [RULE_15]
    end
  end

  // ****************************************
  // Register bus read
  // ****************************************
  wire [7:0] rd_mux =
    (bus_addr == A_ACC)    ? acc_reg                       :
    (bus_addr == A_STATUS) ? {3'h0, status_reg}            :
    (bus_addr == A_OPTION) ? {4'h0, option_reg}            :
    (bus_addr == A_PC)     ? pc_reg[7:0]                   :
    (bus_addr == A_TRIS)   ? tris_reg                      :
    (bus_addr == A_TIMER)  ? tmr_reg                       :
    (bus_addr == A_STATE)  ? {6'h00, asleep_reg, flush_reg} :
    8'h00;

  // ****************************************
  // Sequential state
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_reg    <= 8'h00;
      status_reg <= STATUS_RST;
      tmr_reg    <= 8'h00;
      presc_reg  <= 8'h00;
      wdt_reg    <= '0;
    end else begin
      acc_reg    <= acc_next;
      status_reg <= status_next;
      tmr_reg    <= tmr_next;
      presc_reg  <= presc_next;
      wdt_reg    <= wdt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_reg     <= 11'h000;
      sp_reg     <= '0;
      flush_reg  <= 1'b0;
    end else begin
      pc_reg     <= pc_next;
      sp_reg     <= do_call ? sp_inc : do_ret ? sp_dec : sp_reg;
      flush_reg  <= skip | do_call | do_goto | do_ret;   // [RULE_16]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      asleep_reg  <= 1'b0;
      wdt_rst_reg <= 1'b0;
    end else begin
      asleep_reg  <= wdt_to ? 1'b0 : (asleep_reg | do_sleep);
      wdt_rst_reg <= wdt_to & ~asleep_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      option_reg <= OPTION_RST;
      tris_reg   <= TRIS_RST;
      latch_reg  <= 8'h00;
      rdata_reg  <= 8'h00;
    end else begin
      if (bus_wr && bus_addr == A_OPTION) begin
        option_reg <= bus_wdata[3:0];
      end
      if (bus_wr && bus_addr == A_TRIS) begin
        tris_reg <= bus_wdata;
      end
      if (wr_f && at_prt) begin
        latch_reg <= res;                      // [RULE_17]
      end
      rdata_reg <= bus_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // File memory and return stack
  // ****************************************
  for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_mem
    always_ff @(posedge clk) begin
      if (srst) begin
        mem[i] <= 8'h00;
      end else if (wr_f && !at_prt && !at_tmr && fidx == FW'(i)) begin
        mem[i] <= res;
      end
    end
  end

  for (genvar j = 0; j < STACK_DEPTH; j++) begin : g_stk
    always_ff @(posedge clk) begin
      if (srst) begin
        stack[j] <= 11'h000;
      end else if (do_call && sp_reg == SW'(j)) begin
        stack[j] <= pc_inc;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign fetch_addr = pc_reg;
  assign nop_cycle  = flush_reg;
  assign port_out   = latch_reg;
  assign port_oe_n  = tris_reg;
  assign bus_rdata  = rdata_reg;
  assign wdt_reset  = wdt_rst_reg;
  assign asleep     = asleep_reg;

endmodule

/* logic/idc_dec_if.sv */
// Decoded instruction fields passed from decoder to core
interface idc_dec_if;
  import idc_pkg::*;
  logic [13:0] word;
  idc_op_t     op;
  logic        dest;
  logic [6:0]  fa;
  logic [2:0]  bsel;
  logic [7:0]  lit;
  logic [10:0] target;
  modport dec  (input word, output op, dest, fa, bsel, lit, target);
  modport core (output word, input op, dest, fa, bsel, lit, target);
endinterface

/* logic/idc_decode.sv */
// Combinational decoder of 14-bit instruction words
module idc_decode
  import idc_pkg::*;
(
  idc_dec_if.dec d
);

  // ****************************************
  // Field extraction
  // ****************************************
  wire [5:0] top6 = d.word[13:8];
  wire [4:0] top5 = d.word[13:9];
  wire [3:0] top4 = d.word[13:10];
  wire [2:0] top3 = d.word[13:11];

  assign d.dest   = d.word[7];
  assign d.fa     = d.word[6:0];
  assign d.bsel   = d.word[9:7];
  assign d.lit    = d.word[7:0];
  assign d.target = d.word[10:0];

  // ****************************************
  // Opcode match
  // ****************************************
  assign d.op =
    (top6 == P_XOR)      ? OP_XOR   : // [RULE_01]
    (top6 == P_IOR)      ? OP_IOR   : // [RULE_02]
    (top6 == P_ROTL)     ? OP_ROTL  : // [RULE_03]
    (top6 == P_ROTR)     ? OP_ROTR  : // [RULE_04]
    (top6 == P_DECSZ)    ? OP_DECSZ : // [RULE_05]
    (top6 == P_INCSZ)    ? OP_INCSZ : // [RULE_06]
    (top4 == P_BTC)      ? OP_BTC   : // [RULE_07]
    (top4 == P_BTS)      ? OP_BTS   : // [RULE_08]
    (top6 == P_IORL)     ? OP_IORL  : // [RULE_09]
    (top6 == P_XORL)     ? OP_XORL  : // [RULE_10]
    (top5 == P_SUBL)     ? OP_SUBL  : // [RULE_11]
    (top4 == P_RETL)     ? OP_RETL  : // [RULE_12]
    (d.word == W_SLEEP)  ? OP_SLEEP : // [RULE_13]
    (d.word == W_KICK)   ? OP_KICK  : // [RULE_20]
    (top3 == P_CALL)     ? OP_CALL  : // [RULE_19]
    (top3 == P_GOTO)     ? OP_GOTO  : // [RULE_19]
    OP_OTHER;

endmodule

/* logic/idc_pkg.sv */
// Shared constants, field positions and op codes of the decoder core
package idc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ     = 20;
  localparam int WDT_TIME_US = 18000;
  localparam int WDT_CYCLES  = WDT_TIME_US * CLK_MHZ;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] A_ACC    = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h1;
  localparam logic [3:0] A_OPTION = 4'h2;
  localparam logic [3:0] A_PC     = 4'h3;
  localparam logic [3:0] A_TRIS   = 4'h4;
  localparam logic [3:0] A_TIMER  = 4'h5;
  localparam logic [3:0] A_STATE  = 4'h6;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int ST_C   = 0;
  localparam int ST_NIB = 1;
  localparam int ST_Z   = 2;
  localparam int ST_PWD = 3;
  localparam int ST_TO  = 4;
  localparam int OPT_PSA = 3;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [3:0] OPTION_RST = 4'hf;
  localparam logic [7:0] TRIS_RST   = 8'hff;

  // ****************************************
  // File addresses with side effects
  // ****************************************
  localparam logic [6:0] FA_TIMER = 7'h01;
  localparam logic [6:0] FA_PORT  = 7'h05;

  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [5:0] P_XOR   = 6'h06;
  localparam logic [5:0] P_IOR   = 6'h04;
  localparam logic [5:0] P_ROTL  = 6'h0d;
  localparam logic [5:0] P_ROTR  = 6'h0c;
  localparam logic [5:0] P_DECSZ = 6'h0b;
  localparam logic [5:0] P_INCSZ = 6'h0f;
  localparam logic [3:0] P_BTC   = 4'h6;
  localparam logic [3:0] P_BTS   = 4'h7;
  localparam logic [5:0] P_IORL  = 6'h38;
  localparam logic [5:0] P_XORL  = 6'h3a;
  localparam logic [4:0] P_SUBL  = 5'h1e;
  localparam logic [3:0] P_RETL  = 4'hd;
  localparam logic [2:0] P_CALL  = 3'h4;
  localparam logic [2:0] P_GOTO  = 3'h5;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_KICK  = 14'h0064;

  typedef enum logic [4:0] {
    OP_OTHER = 5'b00000,
    OP_XOR   = 5'b00001,
    OP_IOR   = 5'b00010,
    OP_ROTL  = 5'b00011,
    OP_ROTR  = 5'b00100,
    OP_DECSZ = 5'b00101,
    OP_INCSZ = 5'b00110,
    OP_BTC   = 5'b00111,
    OP_BTS   = 5'b01000,
    OP_IORL  = 5'b01001,
    OP_XORL  = 5'b01010,
    OP_SUBL  = 5'b01011,
    OP_RETL  = 5'b01100,
    OP_SLEEP = 5'b01101,
    OP_KICK  = 5'b01110,
    OP_CALL  = 5'b01111,
    OP_GOTO  = 5'b10000
  } idc_op_t;

endpackage

/* tb/idc_core_properties.sv */
// Port checker for the decoder core
module idc_core_checker
  import idc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [13:0] instr_word,
  input wire logic        instr_valid,
  input wire logic [10:0] fetch_addr,
  input wire logic        nop_cycle,
  input wire logic [7:0]  port_pins,
  input wire logic        wdt_reset,
  input wire logic        asleep
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  wire logic        tk;
  wire logic        bt;
  wire logic        pbit;
  wire logic [10:0] tgt;
  assign tk   = instr_valid && !nop_cycle && !asleep;
  assign bt   = tk && instr_word[13:11] == 3'b011
                && instr_word[6:0] == FA_PORT;
  assign pbit = port_pins[instr_word[9:7]];
  assign tgt  = instr_word[10:0];

  property p_nop_once;
    nop_cycle |=> !nop_cycle;
  endproperty
  a_nop_once: assert property (p_nop_once)
    else $error("idle cycle held too long");
  property p_branch;
    tk && instr_word[13:12] == 2'b10 |=> nop_cycle && fetch_addr == $past(tgt);
  endproperty
  a_branch: assert property (p_branch)
    else $error("call or jump target wrong");
  property p_return;
    tk && instr_word[13:10] == P_RETL |=> nop_cycle;
  endproperty
  a_return: assert property (p_return)
    else $error("return without idle cycle");
  property p_skip_clear;
    bt && !instr_word[10] |=> nop_cycle != $past(pbit)
      && fetch_addr == $past(fetch_addr) + 11'(nop_cycle) + 11'h1;
  endproperty
  a_skip_clear: assert property (p_skip_clear)
    else $error("skip on clear pin bit wrong");
  property p_skip_set;
    bt && instr_word[10] |=> nop_cycle == $past(pbit);
  endproperty
  a_skip_set: assert property (p_skip_set)
    else $error("skip on set pin bit wrong");
  property p_standby;
    tk && instr_word == W_SLEEP |=> asleep [*8];
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not held");
  property p_kick;
    tk && instr_word == W_KICK |-> ##2 !wdt_reset [*8];
  endproperty
  a_kick: assert property (p_kick)
    else $error("time-out right after kick");
  property p_wake;
    $fell(asleep) |-> !wdt_reset;
  endproperty
  a_wake: assert property (p_wake)
    else $error("reset pulse on wake");

  c_branch: cover property (tk && instr_word[13:12] == 2'b10);
  c_skip: cover property (bt ##1 nop_cycle);
  c_wake: cover property ($fell(asleep));
endmodule

bind idc_core idc_core_checker u_checker (
  .clk(clk), .srst(srst), .instr_word(instr_word),
  .instr_valid(instr_valid), .fetch_addr(fetch_addr),
  .nop_cycle(nop_cycle), .port_pins(port_pins), .wdt_reset(wdt_reset),
  .asleep(asleep)
);

/* tb/idc_core_tb_top.sv */
// Self-checking bench of the decoder core against an integer model
module idc_core_tb_top
  import idc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  // ********************
  // Signals and model state
  // ********************
  localparam int LIM = 50;
  localparam logic [13:0] BASE [15] = '{14'h0600, 14'h0400, 14'h0d00,
    14'h0c00, 14'h0b00, 14'h0f00, 14'h1800, 14'h1c00, 14'h3800, 14'h3a00,
    14'h3c00, 14'h2000, 14'h3400, 14'h2800, W_KICK};
  localparam logic [13:0] MSK [15] = '{14'h00ff, 14'h00ff, 14'h00ff,
    14'h00ff, 14'h00ff, 14'h00ff, 14'h03ff, 14'h03ff, 14'h00ff, 14'h00ff,
    14'h01ff, 14'h07ff, 14'h03ff, 14'h07ff, 14'h0000};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [13:0] instr_word;
  logic        instr_valid = 1'b0;
  logic [10:0] fetch_addr;
  logic        nop_cycle;
  logic [7:0]  port_pins = 8'h00;
  logic [7:0]  port_out;
  logic [7:0]  port_oe_n;
  logic [3:0]  bus_addr = 4'h0;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_rdata;
  logic        wdt_reset;
  logic        asleep;
  int          bad_count, check_count, cyc, t0;
  int          m_acc, m_c, m_dc, m_z, m_pc, m_lat, m_sp;
  int          m_f [16];
  int          m_stk [8];

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  idc_core #(.WDT_LIMIT(LIM)) dut (
    .clk(clk), .srst(srst), .instr_word(instr_word),
    .instr_valid(instr_valid), .fetch_addr(fetch_addr),
    .nop_cycle(nop_cycle), .port_pins(port_pins), .port_out(port_out),
    .port_oe_n(port_oe_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .wdt_reset(wdt_reset), .asleep(asleep)
  );
  idc_prog_mem pm (.addr(fetch_addr), .word(instr_word));

  // ********************
  // Checks and bus cycles
  // ********************
  task automatic chk(input string nm, input int e, input logic [15:0] g);
    check_count++;
    if (g !== 16'(e)) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, 16'(e), g);
    end
  endtask

  task automatic bwr(input logic [3:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(string nm, logic [3:0] a, int e, logic [7:0] mk);
    logic [7:0] d;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    chk(nm, e & mk, 16'(d & mk));
    @(posedge clk);
  endtask

  task automatic run(input logic [13:0] w);
    int v, r, k, fa, sk, br, op;
    pm.mem[m_pc] = w;
    port_pins <= 8'($urandom);
    instr_valid <= 1'b1;
    @(posedge clk);
    fa = w[6:0] % 16;
    v = (w[6:0] == FA_PORT) ? port_pins : m_f[fa];
    k = w[7:0];
    op = w[11:8];
    sk = 0;
    br = 0;
    if (w[13:12] == 2'b00 && op != 0) begin
      r = (op == 6) ? m_acc ^ v : (op == 4) ? m_acc | v :
          (op == 13) ? (v << 1 | m_c) & 255 : (op == 12) ? v >> 1 | m_c << 7 :
          (op == 11) ? (v + 255) & 255 : (v + 1) & 255;
      if (op == 13 || op == 12) m_c = (op == 13) ? v >> 7 : v & 1;
      if (op == 6 || op == 4) m_z = (r == 0);
      sk = (op == 11 || op == 15) && r == 0;
      if (!w[7]) m_acc = r;
      else if (w[6:0] == FA_PORT) m_lat = r;
      else m_f[fa] = r;
    end else if (w[13:12] == 2'b01) begin
      sk = ((v >> w[9:7]) & 1) == w[10];
    end else if (w[13:12] == 2'b10) begin
      if (!w[11]) m_stk[m_sp] = (m_pc + 1) & 2047;
      if (!w[11]) m_sp = (m_sp + 1) % 8;
      br = 1;
      m_pc = w[10:0];
    end else if (w[13:10] == P_RETL) begin
      m_sp = (m_sp + 7) % 8;
      br = 1;
      m_pc = m_stk[m_sp];
      m_acc = k;
    end else if (w[13:10] == 4'he) begin
      m_acc = w[9] ? m_acc ^ k : m_acc | k;
      m_z = (m_acc == 0);
    end else if (w[13:9] == P_SUBL) begin
      r = k - m_acc;
      m_c = (r >= 0);
      m_dc = ((k & 15) >= (m_acc & 15));
      m_acc = r & 255;
      m_z = (m_acc == 0);
    end
    if (!br) m_pc = (m_pc + 1 + sk) & 2047;
    if (!(sk || br)) instr_valid <= 1'b0;
    #1 t0 = cyc;
    if (sk || br) pm.mem[m_pc] = 14'h3aff;
    chk("fetch_addr", m_pc, 16'(fetch_addr));
    chk("nop_cycle", sk | br, 16'(nop_cycle));
    chk("port_out", m_lat, 16'(port_out));
    @(posedge clk);
    if (sk || br) instr_valid <= 1'b0;
    if (sk || br) @(posedge clk);
    rchk("acc", A_ACC, m_acc, 8'hff);
    rchk("status", A_STATUS, m_z << 2 | m_dc << 1 | m_c, 8'h07);
  endtask

  task automatic wait_span(input string nm, input logic lvl);
    int n;
    n = t0;
    #1;
    while ((lvl ? wdt_reset : asleep) !== lvl && cyc - n < LIM + 20) begin
      @(posedge clk);
      #1;
    end
    chk(nm, 1, 16'(cyc - n >= LIM - 1 && cyc - n <= LIM + 2));
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ********************
  // Test sequence
  // ********************
  initial begin
    int n;
    logic [13:0] w;
    void'($urandom(81026));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rchk("acc", A_ACC, 0, 8'hff);
    rchk("status", A_STATUS, STATUS_RST, 8'hff);
    rchk("option", A_OPTION, OPTION_RST, 8'hff);
    rchk("tris", A_TRIS, TRIS_RST, 8'hff);
    rchk("unmapped", 4'hb, 0, 8'hff);
    n = $urandom % 256;
    bwr(A_TRIS, 8'(n));
    chk("port_oe_n", n, 16'(port_oe_n));
    m_acc = $urandom % 256;
    bwr(A_ACC, 8'(m_acc));
    $display("test registers done");
    for (int i = 0; i < 300; i++) begin
      n = $urandom;
      w = BASE[i % 15] | (14'(n) & MSK[i % 15]);
      if (i % 15 < 8) w[6:0] = n[20] ? FA_PORT : {4'h1, n[2:0]};
      run(w);
      if (w == W_KICK) rchk("status", A_STATUS, 8'h18, 8'h18);
    end
    for (int j = 0; j < 2; j++) begin
      m_acc = m_f[8] ^ (j ? 255 : 1);
      bwr(A_ACC, 8'(m_acc));
      run(14'h0688);
      run(j ? 14'h0f88 : 14'h0b88);
    end
    $display("test decode done");
    bwr(A_OPTION, 8'h00);
    run(W_KICK);
    repeat (30) @(posedge clk);
    run(W_KICK);
    wait_span("wdt_span", 1'b1);
    @(posedge clk);
    rchk("status", A_STATUS, 8'h08, 8'h18);
    run(W_KICK);
    rchk("status", A_STATUS, 8'h18, 8'h18);
    $display("test watchdog done");
    run(W_SLEEP);
    rchk("status", A_STATUS, 8'h10, 8'h18);
    chk("asleep", 1, 16'(asleep));
    pm.mem[m_pc] = 14'h3aff;
    instr_valid <= 1'b1;
    wait_span("wake_span", 1'b0);
    instr_valid <= 1'b0;
    @(posedge clk);
    rchk("acc", A_ACC, m_acc, 8'hff);
    rchk("status", A_STATUS, 8'h00, 8'h18);
    $display("test standby done");
    end_sim();
  end

  // Cut a hang short well past the expected run length
  initial begin
    #(50 * 20000);
    bad_count++;
    end_sim();
  end
endmodule

/* tb/idc_prog_mem.sv */
// Program memory model that feeds instruction words to the core
module idc_prog_mem (
  input  wire logic [10:0] addr,
  output logic      [13:0] word
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [13:0] mem [0:2047];

  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 14'h0000;
    end
  end

  // ********************
  // Word at the fetch address, no wait state
  // ********************
  assign word = mem[addr];
endmodule
